//--- core/cir_config_identity_registers.sv
// Read-only identity registers and reset-release pin capture register.
`timescale 1ns/1ps
`default_nettype none
module cir_config_identity_registers #(
   parameter logic [15:0] VENDOR_CODE = 16'h5a3c, // Arbitrary value.
   parameter logic [7:0] PRODUCT_CODE = 8'h7e, // Arbitrary value.
   parameter logic [7:0] DIE_REVISION = 8'h04 // Arbitrary value.
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Configuration pads, asynchronous.
   input wire cir_pkg::cir_pins_t pins,
   // Non-volatile memory load path, same clock.
   input wire logic nvmSerialValid,
   input wire logic [7:0] nvmSerialData,
   // Register port.
   input wire cir_pkg::cir_req_t req,
   output logic regAck,
   output logic [7:0] regRdata
);
   import cir_pkg::*;

   // ----------------------------------------------------------------------
   // Pad synchronisers
   // ----------------------------------------------------------------------
   cir_pins_t pinsMeta_ff;
   cir_pins_t pinsSync_ff;

   // Pads are asynchronous, so two flops precede any use; no reset needed.
   // Only the second flop is read; the first may still be settling.
   always_ff @(posedge clk_sys) begin
      pinsMeta_ff <= pins;
      pinsSync_ff <= pinsMeta_ff;
   end

   // ----------------------------------------------------------------------
   // Soft pin pair encoding
   // ----------------------------------------------------------------------
   logic [2:0] lowerCode;
   logic [2:0] pairCode;

   // An illegal lower level is read as high rather than inventing a code 6.
   // Legal levels form codes 0 to 5 only; 6 and 7 never leave here.
   always_comb begin
      unique case (pinsSync_ff.lowerLevel)
         CIR_LVL_LOW: lowerCode = 3'h0;
         CIR_LVL_MID: lowerCode = 3'h1;
         default: lowerCode = 3'h2;
      endcase
      // Upper pin adds three steps above the lower level.
      pairCode = pinsSync_ff.upperPin ? 3'(lowerCode + CODE_UPPER_STEP)
                                      : lowerCode;
   end

   // ----------------------------------------------------------------------
   // Capture at reset release
   // ----------------------------------------------------------------------
   logic capDone_ff;
   logic [7:0] capture_ff;
   logic [7:0] nxt_capture;

   always_comb begin
      nxt_capture = CAPTURE_RESET; // Reserved bits stay zero.
      nxt_capture[SRC_BIT] = pinsSync_ff.srcPin;
      // Hard mode hides the pair code.
      nxt_capture[CODE_MSB:CODE_LSB] = pinsSync_ff.srcPin ? CODE_HARD
                                                          : pairCode;
   end

   // The first edge after release takes the pins, then they freeze.
   // Pads must be steady two edges before release, or the old level still
   // sitting in the synchroniser is what gets frozen.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         capDone_ff <= 1'b0;
         capture_ff <= CAPTURE_RESET;
      end else if (!capDone_ff) begin
         capDone_ff <= 1'b1;
         capture_ff <= nxt_capture;
      end
   end

   // ----------------------------------------------------------------------
   // Unit serial byte
   // ----------------------------------------------------------------------
   logic serialLoaded_ff;
   logic [7:0] serial_ff;

   // Only the first memory word after reset is taken; nothing else writes.
   // A stray later word is dropped silently, as the byte is factory data.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         serialLoaded_ff <= 1'b0;
         serial_ff <= SERIAL_RESET;
      end else if (nvmSerialValid && !serialLoaded_ff) begin
         serialLoaded_ff <= 1'b1;
         serial_ff <= nvmSerialData;
      end
   end

   // ----------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------
   logic [7:0] nxt_rdata;

   // Every register is read-only, so write data is dropped.
   always_comb begin
      unique case (req.addr)
         OFF_VENDOR_HIGH: nxt_rdata = VENDOR_CODE[15:8];
         OFF_VENDOR_LOW: nxt_rdata = VENDOR_CODE[7:0];
         OFF_PRODUCT: nxt_rdata = PRODUCT_CODE;
         OFF_REVISION: nxt_rdata = DIE_REVISION;
         OFF_SERIAL: nxt_rdata = serial_ff;
         OFF_SOFT_CAPTURE: nxt_rdata = capture_ff;
         default: nxt_rdata = READ_IDLE;
      endcase
   end

   // Answer one cycle after the request; writes are acknowledged only.
   // Unmapped offsets answer zero, so probing the map is harmless.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         regAck <= 1'b0;
         regRdata <= READ_IDLE;
      end else begin
         regAck <= req.rd || req.wr;
         regRdata <= req.rd ? nxt_rdata : READ_IDLE;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Checks sleep while reset is low and wake on the first edge after it.

   // Fixed identity bytes read back on the cycle after the request.
   a_vendor_low_read: assert property (
      req.rd && req.addr == OFF_VENDOR_LOW |=>
         regAck && regRdata == VENDOR_CODE[7:0])
      else $error("Vendor low byte read wrong.");
   a_vendor_high_read: assert property (
      req.rd && req.addr == OFF_VENDOR_HIGH |=>
         regRdata == VENDOR_CODE[15:8])
      else $error("Vendor high byte read wrong.");
   a_product_read: assert property (
      req.rd && req.addr == OFF_PRODUCT |=> regRdata == PRODUCT_CODE)
      else $error("Product code read wrong.");
   a_revision_read: assert property (
      req.rd && req.addr == OFF_REVISION |=> regRdata == DIE_REVISION)
      else $error("Revision code read wrong.");

   // Serial byte: taken once from memory, then frozen.
   a_serial_load: assert property (
      nvmSerialValid && !serialLoaded_ff |=>
         serialLoaded_ff && serial_ff == $past(nvmSerialData))
      else $error("Serial byte not loaded.");
   a_serial_fixed: assert property (
      serialLoaded_ff |=> $stable(serial_ff) [*3])
      else $error("Serial byte changed after load.");
   a_serial_empty: assert property (
      !serialLoaded_ff |-> serial_ff == SERIAL_RESET)
      else $error("Serial byte set before any load.");

   // Capture register: taken at release, then held until the next reset.
   a_capture_hold: assert property (
      capDone_ff |=> capDone_ff && $stable(capture_ff))
      else $error("Capture register changed.");
   a_source_bit: assert property (
      $rose(capDone_ff) |->
         capture_ff[SRC_BIT] == $past(pinsSync_ff.srcPin))
      else $error("Source pin capture wrong.");
   a_pair_code: assert property (
      $rose(capDone_ff) && !capture_ff[SRC_BIT] |->
         capture_ff[CODE_MSB:CODE_LSB] == $past(pairCode))
      else $error("Pin pair code wrong.");
   a_hard_zero: assert property (
      capDone_ff && capture_ff[SRC_BIT] |->
         capture_ff[CODE_MSB:CODE_LSB] == CODE_HARD)
      else $error("Pair code not zero in hard mode.");
   a_reserved_zero: assert property (
      req.rd && req.addr == OFF_SOFT_CAPTURE |=> regRdata[3:0] == 4'h0)
      else $error("Reserved capture bits not zero.");

   // Register port: one acknowledge per request, data only for reads.
   // A stray or missing acknowledge would shift every answer the host
   // pairs with its requests, so both directions are checked.
   a_ack_follows: assert property (
      req.rd || req.wr |=> regAck)
      else $error("Request not acknowledged.");
   a_ack_single: assert property (
      !(req.rd || req.wr) |=> !regAck)
      else $error("Acknowledge without request.");
   a_read_idle: assert property (
      !req.rd |=> regRdata == READ_IDLE)
      else $error("Read data outside a read.");

   // Live registers return the value they held when the read was taken.
   a_serial_read: assert property (
      req.rd && req.addr == OFF_SERIAL |=> regRdata == $past(serial_ff))
      else $error("Serial byte read wrong.");
   a_capture_read: assert property (
      req.rd && req.addr == OFF_SOFT_CAPTURE |=>
         regRdata == $past(capture_ff))
      else $error("Capture register read wrong.");

   // Host writes reach no storage at all.
   a_serial_write: assert property (
      req.wr && serialLoaded_ff |=> $stable(serial_ff))
      else $error("Write changed the serial byte.");
   a_capture_write: assert property (
      req.wr && capDone_ff |=> $stable(capture_ff))
      else $error("Write changed the capture register.");

   // Main scenarios: both capture modes, serial read, write, stray load.
   c_soft_mode: cover property ($rose(capDone_ff) && !capture_ff[SRC_BIT]);
   c_hard_mode: cover property ($rose(capDone_ff) && capture_ff[SRC_BIT]);
   c_serial_read: cover property (
      serialLoaded_ff && req.rd && req.addr == OFF_SERIAL);
   c_write_try: cover property (req.wr && req.addr == OFF_SERIAL);
   c_stray_word: cover property (nvmSerialValid && serialLoaded_ff);

endmodule
`default_nettype wire

//--- core/cir_pkg.sv
// Constants and types shared by the identity and configuration capture bank.
package cir_pkg;

   // ----------------------------------------------------------------------
   // Register offsets and layout
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFF_VENDOR_HIGH = 8'h00;
   localparam logic [7:0] OFF_VENDOR_LOW = 8'h01;
   localparam logic [7:0] OFF_PRODUCT = 8'h02;
   localparam logic [7:0] OFF_REVISION = 8'h03;
   localparam logic [7:0] OFF_SERIAL = 8'h04;
   localparam logic [7:0] OFF_SOFT_CAPTURE = 8'h08;
   localparam int SRC_BIT = 7;
   localparam int CODE_LSB = 4;
   localparam int CODE_MSB = 6;
   localparam logic [7:0] READ_IDLE = 8'h00;
   localparam logic [7:0] SERIAL_RESET = 8'h00;
   localparam logic [7:0] CAPTURE_RESET = 8'h00;
   localparam logic [2:0] CODE_HARD = 3'h0;
   localparam logic [2:0] CODE_UPPER_STEP = 3'h3;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   // Level seen on the tri-level lower pin of the soft pin pair.
   typedef enum logic [1:0] {
      CIR_LVL_LOW = 2'h0,
      CIR_LVL_MID = 2'h1,
      CIR_LVL_HIGH = 2'h2
   } cir_level_t;

   // Configuration pins as they arrive from the pads.
   typedef struct packed {
      logic srcPin;
      logic upperPin;
      logic [1:0] lowerLevel;
   } cir_pins_t;

   // Register port request from the serial port logic.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cir_req_t;

endpackage

//--- sim/cir_nvm_model.sv
// Behavioural non-volatile memory feeding the unit serial byte.
`timescale 1ns/1ps
`default_nettype none
module cir_nvm_model (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Byte this unit was given at the factory.
   input wire logic [7:0] loadByte,
   // Load path towards the register bank.
   output logic nvmSerialValid,
   output logic [7:0] nvmSerialData
);
   logic [2:0] stepCnt;

   // The byte is offered once after reset, then a stray word follows that
   // must be ignored; the data lines churn so stale values cannot match.
   // The first word is the load, the second the stray one.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stepCnt <= 3'h0;
      end else if (stepCnt != 3'h7) begin
         stepCnt <= stepCnt + 3'h1;
      end
      nvmSerialValid <= rst_n && (stepCnt == 3'h1 || stepCnt == 3'h4);
      nvmSerialData <= (stepCnt == 3'h1) ? loadByte
                       : ~loadByte ^ {5'h00, stepCnt};
   end
endmodule
`default_nettype wire

//--- sim/cir_config_identity_registers_test.sv
// Self-checking bench for the identity and pin capture register bank.
`timescale 1ns/1ps
`default_nettype none
module cir_config_identity_registers_test;
   import cir_pkg::*;
   localparam logic [15:0] VEND = 16'h9c41; // Arbitrary value.
   localparam logic [7:0] PROD = 8'h5d; // Arbitrary value.
   localparam logic [7:0] REV = 8'h07; // Arbitrary value.
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   cir_pins_t pins = '0;
   cir_req_t req = '0;
   logic nvmSerialValid;
   logic [7:0] nvmSerialData;
   logic [7:0] loadByte = 8'h00;
   logic regAck;
   logic [7:0] regRdata;
   logic [8:0] notes[$];
   logic [8:0] note;
   logic [7:0] capExp;
   logic [7:0] offs[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h05};
   logic [7:0] want[7];
   int failures = 0;
   int checks = 0;
   int seed = 32'h6b38cae5;

   // ----------------------------------------------------------------------
   // Clock, design and partner
   // ----------------------------------------------------------------------
   always #5 clk_sys = ~clk_sys;
   cir_config_identity_registers #(.VENDOR_CODE(VEND), .PRODUCT_CODE(PROD),
      .DIE_REVISION(REV)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .pins(pins), .nvmSerialValid(nvmSerialValid),
      .nvmSerialData(nvmSerialData), .req(req), .regAck(regAck),
      .regRdata(regRdata));
   cir_nvm_model u_nvm (.clk_sys(clk_sys), .rst_n(rst_n),
      .loadByte(loadByte), .nvmSerialValid(nvmSerialValid),
      .nvmSerialData(nvmSerialData));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One request per falling edge; holding req means back-to-back traffic.
   task automatic access(input logic wr, input logic [7:0] addr,
                         input logic [7:0] exp);
      @(negedge clk_sys);
      req = '{rd: !wr, wr: wr, addr: addr, wdata: 8'($random(seed))};
      notes.push_back({!wr, exp});
   endtask

   // Each acknowledge consumes the oldest note; write acks carry no data.
   always @(negedge clk_sys) begin
      if (regAck === 1'b1) begin
         if (notes.size() == 0) begin
            check({7'h00, regAck}, 8'h00);
         end else begin
            note = notes.pop_front();
            if (note[8]) begin
               check(regRdata, note[7:0]);
            end else begin
               check(regRdata, 8'h00);
            end
         end
      end
   end

   initial begin
      #100000;
      failures++;
      close_out();
   end

   // Six soft codes, then hard mode with random pair levels, each reset.
   initial begin
      for (int k = 0; k < 8; k++) begin
         pins.srcPin = (k >= 6);
         pins.upperPin = (k < 6) ? 1'(k / 3) : 1'($random(seed));
         pins.lowerLevel = (k < 6) ? 2'(k % 3) : 2'($random(seed));
         capExp = (k < 6) ? {1'b0, 3'(k), 4'h0} : 8'h80;
         loadByte = 8'($random(seed));
         want = '{VEND[15:8], VEND[7:0], PROD, REV, loadByte, capExp, 8'h00};
         req = '0;
         rst_n = 1'b0;
         repeat (3) @(negedge clk_sys);
         rst_n = 1'b1;
         access(1'b0, OFF_SOFT_CAPTURE, capExp);
         pins = cir_pins_t'(~pins);
         for (int i = 0; i < 7; i++) access(1'b1, offs[i], 8'h00);
         for (int i = 0; i < 7; i++) access(1'b0, offs[i], want[i]);
         access(1'b0, OFF_SERIAL, loadByte);
         @(negedge clk_sys);
         req = '0;
         for (int w = 0; w < 4 && notes.size() != 0; w++) @(negedge clk_sys);
         if (notes.size() != 0) begin
            check(8'(notes.size()), 8'h00);
            break;
         end
      end
      close_out();
   end
endmodule
`default_nettype wire
